// >>> src/ortc_pkg.sv
package ortc_pkg;

	// Display control register layout
	localparam int unsigned CTRL_W          = 8;
	localparam int unsigned BIT_PAGE_EN     = 0;
	localparam int unsigned BIT_WINDOW_EN   = 1;
	localparam int unsigned BIT_XFER_REQ    = 2;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  LIMIT_RESET     = 8'h00;

	// Register selects of the register port
	localparam logic [1:0]  SEL_CONTROL     = 2'h0;
	localparam logic [1:0]  SEL_UPPER       = 2'h1;
	localparam logic [1:0]  SEL_LOWER       = 2'h2;
	localparam logic [1:0]  SEL_IMMEDIATE   = 2'h3;

	// Immediate register file size
	localparam int unsigned IMM_DEPTH       = 16;
	localparam int unsigned IMM_AW          = 4;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] sel;
		logic [3:0] idx;
		logic [7:0] wdata;
	} ortc_cpu_req_t;

	typedef struct packed {
		logic       page_en;
		logic       window_en;
		logic [7:0] upper;
		logic [7:0] lower;
	} ortc_engine_cfg_t;

	typedef enum logic [1:0] {
		ORTC_IDLE,
		ORTC_WAIT_EDGE,
		ORTC_WAIT_LINE_END
	} ortc_state_t;

endpackage

// >>> src/ortc_imm_mem.sv
`timescale 1ns/1ns
module ortc_imm_mem #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4,
	parameter int unsigned DW    = 8
) (
	// Clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          ce_i,
	// Port
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	output logic      [DW-1:0] rdata_o
);
	logic [DW-1:0] mem_reg [DEPTH];

	if (DEPTH == 0 || DEPTH > (1 << AW)) begin : g_depth_check
		$error("DEPTH does not fit AW");
	end

	// Written values take effect at once
	always_ff @(posedge core_clk_i) begin
		if (ce_i && we_i) begin
			mem_reg[addr_i] <= wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= mem_reg[addr_i];
		end
	end
endmodule

// >>> src/ortc_top.sv
`timescale 1ns/1ns
// Functional notes
// - Request outside display area copies deferred registers at next sync falling edge.
// - Request inside a display line, even display-off, copies at that line's ending edge.
// - Immediate registers apply on write, no transfer; the request bit too.
// - Writing 1 to bit 2 requests transfer; hardware clears it after copy.
// - Bit 2 reads 1 while transfer pending, 0 once completed.
// - Bit 0 of display control gates the whole page display.
// - Window enabled limits page vertically between upper and lower registers.
// - Bit 1 of display control enables window limiting.
module ortc_top #(
	parameter int unsigned IMM_DEPTH = ortc_pkg::IMM_DEPTH
) (
	// Clock and reset
	input  wire logic                      core_clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      ce_i,
	// CPU register port
	input  wire ortc_pkg::ortc_cpu_req_t   cpu_req_i,
	output logic      [7:0]                cpu_rdata_o,
	// Video timing
	input  wire logic                      horizontal_sync_i,
	input  wire logic                      in_display_line_i,
	input  wire logic [7:0]                scan_line_i,
	// Display engine
	output ortc_pkg::ortc_engine_cfg_t     engine_cfg_o,
	output logic                           page_visible_o,
	output logic                           xfer_done_o,
	output logic      [7:0]                imm_rdata_o,
	output logic                           imm_wr_o,
	output logic      [3:0]                imm_idx_o,
	output logic      [7:0]                imm_wdata_o
);
	ortc_pkg::ortc_state_t state_reg;
	logic       page_en_reg;
	logic       window_en_reg;
	logic [7:0] upper_reg;
	logic [7:0] lower_reg;
	logic       hsync_d_reg;
	logic       hsync_fall;
	logic       ctrl_wr;
	logic       req_set;
	logic       copy_now;
	logic [7:0] ctrl_rd;
	logic [7:0] imm_mem_rdata;
	logic       line_in_window;
	logic       imm_we;

	// Refuse sizes that the immediate file cannot address
	if (IMM_DEPTH == 0 || IMM_DEPTH > (1 << ortc_pkg::IMM_AW)) begin : g_depth_check
		$error("IMM_DEPTH out of range");
	end
	if (ortc_pkg::BIT_XFER_REQ >= ortc_pkg::CTRL_W) begin : g_bit_check
		$error("Request bit outside the control register");
	end

	assign hsync_fall = hsync_d_reg && !horizontal_sync_i;
	assign imm_we     = cpu_req_i.wr && (cpu_req_i.sel == ortc_pkg::SEL_IMMEDIATE);
	assign ctrl_wr    = cpu_req_i.wr && (cpu_req_i.sel == ortc_pkg::SEL_CONTROL);
	// Only a 1 starts a transfer; a written 0 is ignored
	assign req_set    = ctrl_wr && cpu_req_i.wdata[ortc_pkg::BIT_XFER_REQ];
	assign copy_now   = hsync_fall && ((state_reg == ortc_pkg::ORTC_WAIT_EDGE) ||
		((state_reg == ortc_pkg::ORTC_WAIT_LINE_END) && !in_display_line_i));

	// Cleared by reset, so a pin held low gives no false fall
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hsync_d_reg <= 1'b0;
		end else if (ce_i) begin
			hsync_d_reg <= horizontal_sync_i;
		end
	end

	// Deferred registers hold CPU writes until the copy
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page_en_reg   <= 1'b0;
			window_en_reg <= 1'b0;
			upper_reg     <= ortc_pkg::LIMIT_RESET;
			lower_reg     <= ortc_pkg::LIMIT_RESET;
		end else if (ce_i && cpu_req_i.wr) begin
			// Writes while pending land here and may corrupt the copy
			case (cpu_req_i.sel)
				ortc_pkg::SEL_CONTROL: begin
					page_en_reg   <= cpu_req_i.wdata[ortc_pkg::BIT_PAGE_EN];
					window_en_reg <= cpu_req_i.wdata[ortc_pkg::BIT_WINDOW_EN];
				end
				ortc_pkg::SEL_UPPER: upper_reg <= cpu_req_i.wdata;
				ortc_pkg::SEL_LOWER: lower_reg <= cpu_req_i.wdata;
				default: ;
			endcase
		end
	end

	// Transfer sequencer
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ortc_pkg::ORTC_IDLE;
		end else if (ce_i) begin
			case (state_reg)
				ortc_pkg::ORTC_IDLE: begin
					if (req_set) begin
						if (in_display_line_i) begin
							state_reg <= ortc_pkg::ORTC_WAIT_LINE_END;
						end else begin
							state_reg <= ortc_pkg::ORTC_WAIT_EDGE;
						end
					end
				end
				ortc_pkg::ORTC_WAIT_EDGE: begin
					if (copy_now) begin
						state_reg <= ortc_pkg::ORTC_IDLE;
					end
				end
				ortc_pkg::ORTC_WAIT_LINE_END: begin
					// Line status is sampled in the same cycle as the sync falling edge
					if (copy_now) begin
						state_reg <= ortc_pkg::ORTC_IDLE;
					end
				end
				default: state_reg <= ortc_pkg::ORTC_IDLE;
			endcase
		end
	end

	// Copy into the engine; bit 0 and bit 1 only act from here
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			engine_cfg_o <= '0;
		end else if (ce_i) begin
			if (copy_now) begin
				engine_cfg_o.page_en   <= page_en_reg;
				engine_cfg_o.window_en <= window_en_reg;
				engine_cfg_o.upper     <= upper_reg;
				engine_cfg_o.lower     <= lower_reg;
			end
		end
	end

	// Done pulse, in the same cycle as the copied values
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xfer_done_o <= 1'b0;
		end else if (ce_i) begin
			xfer_done_o <= copy_now;
		end
	end

	// Page gate and vertical window on the current scan line
	assign line_in_window = (scan_line_i >= engine_cfg_o.upper) &&
		(scan_line_i <= engine_cfg_o.lower);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page_visible_o <= 1'b0;
		end else if (ce_i) begin
			page_visible_o <= engine_cfg_o.page_en &&
				(!engine_cfg_o.window_en || line_in_window);
		end
	end

	// Immediate registers pass straight through on write
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			imm_wr_o    <= 1'b0;
			imm_idx_o   <= '0;
			imm_wdata_o <= '0;
		end else if (ce_i) begin
			imm_wr_o    <= imm_we;
			imm_idx_o   <= cpu_req_i.idx;
			imm_wdata_o <= cpu_req_i.wdata;
		end
	end

	ortc_imm_mem #(
		.DEPTH (IMM_DEPTH),
		.AW    (ortc_pkg::IMM_AW),
		.DW    (8)
	) u_imm_mem (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.ce_i       (ce_i),
		.we_i       (imm_we),
		.addr_i     (cpu_req_i.idx),
		.wdata_i    (cpu_req_i.wdata),
		.rdata_o    (imm_mem_rdata)
	);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			imm_rdata_o <= '0;
		end else if (ce_i) begin
			imm_rdata_o <= imm_mem_rdata;
		end
	end

	// Status read; pending flag set the cycle after the request write
	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[ortc_pkg::BIT_PAGE_EN]   = page_en_reg;
		ctrl_rd[ortc_pkg::BIT_WINDOW_EN] = window_en_reg;
		ctrl_rd[ortc_pkg::BIT_XFER_REQ]  = (state_reg != ortc_pkg::ORTC_IDLE);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_rdata_o <= ortc_pkg::CTRL_RESET;
		end else if (ce_i && cpu_req_i.rd) begin
			case (cpu_req_i.sel)
				ortc_pkg::SEL_CONTROL: cpu_rdata_o <= ctrl_rd;
				ortc_pkg::SEL_UPPER:   cpu_rdata_o <= upper_reg;
				ortc_pkg::SEL_LOWER:   cpu_rdata_o <= lower_reg;
				default:               cpu_rdata_o <= 8'h00;
			endcase
		end
	end
endmodule

// >>> test/ortc_props.sv
`timescale 1ns/1ns
module ortc_props (
	// Clock and reset
	input wire logic                       core_clk_i,
	input wire logic                       rst_n_i,
	input wire logic                       ce_i,
	// Watched ports
	input wire ortc_pkg::ortc_cpu_req_t    cpu_req_i,
	input wire logic [7:0]                 cpu_rdata_o,
	input wire logic                       horizontal_sync_i,
	input wire logic                       in_display_line_i,
	input wire logic [7:0]                 scan_line_i,
	input wire ortc_pkg::ortc_engine_cfg_t engine_cfg_o,
	input wire logic                       page_visible_o,
	input wire logic                       xfer_done_o,
	input wire logic                       imm_wr_o,
	input wire logic [7:0]                 imm_wdata_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire wr_c = ce_i && cpu_req_i.wr && cpu_req_i.sel == ortc_pkg::SEL_CONTROL;
	wire rd_c = ce_i && cpu_req_i.rd && cpu_req_i.sel == ortc_pkg::SEL_CONTROL;
	wire req = wr_c && cpu_req_i.wdata[ortc_pkg::BIT_XFER_REQ];
	wire in_w = scan_line_i >= engine_cfg_o.upper && scan_line_i <= engine_cfg_o.lower;
	wire want = engine_cfg_o.page_en && (!engine_cfg_o.window_en || in_w);
	// Shadow of the pending flag, seen from the ports only
	logic busy_reg;
	logic line_req_reg;
	wire  flag_exp = busy_reg && !xfer_done_o;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg     <= 1'b0;
			line_req_reg <= 1'b0;
		end else if (ce_i) begin
			if (req && !flag_exp) begin
				busy_reg     <= 1'b1;
				line_req_reg <= in_display_line_i;
			end else if (xfer_done_o) begin
				busy_reg <= 1'b0;
			end
		end
	end
	AST_DONE_PULSE: assert property (xfer_done_o && ce_i |=> !xfer_done_o)
		else $error("done pulse too long");
	AST_CFG_ON_COPY: assert property (!$stable(engine_cfg_o) |-> xfer_done_o)
		else $error("config changed without copy");
	AST_SYNC_FALL: assert property (xfer_done_o |-> $past(horizontal_sync_i, 2)
		&& !$past(horizontal_sync_i)) else $error("copy not on sync fall");
	AST_LINE_END: assert property (xfer_done_o && line_req_reg
		|-> !$past(in_display_line_i)) else $error("copy inside display line");
	AST_FLAG_SET: assert property (req ##2 rd_c ##1 !cpu_req_i.rd |=> cpu_rdata_o[2])
		else $error("flag not set");
	AST_FLAG_CLR: assert property (rd_c |=> cpu_rdata_o[2] == $past(flag_exp))
		else $error("flag not cleared");
	AST_IMM_ECHO: assert property (ce_i && cpu_req_i.wr && cpu_req_i.sel == 2'h3
		|=> imm_wr_o && imm_wdata_o == $past(cpu_req_i.wdata)) else $error("no echo");
	// Only steady inputs, as the output is registered
	AST_VISIBLE: assert property ($stable(engine_cfg_o) && $stable(scan_line_i)
		&& $past(ce_i) |-> page_visible_o == want) else $error("visibility wrong");
	cover property (xfer_done_o);
	cover property (page_visible_o && engine_cfg_o.window_en);
	cover property (imm_wr_o);
	cover property (xfer_done_o && line_req_reg);
endmodule
bind ortc_top ortc_props u_props (.*);

// >>> test/ortc_top_tb_top.sv
`timescale 1ns/1ns
module ortc_top_tb_top;
	logic                       core_clk_i, rst_n_i, ce_i;
	logic                       horizontal_sync_i, in_display_line_i;
	logic [7:0]                 scan_line_i, cpu_rdata_o, imm_rdata_o, imm_wdata_o;
	ortc_pkg::ortc_cpu_req_t    cpu_req_i;
	ortc_pkg::ortc_engine_cfg_t engine_cfg_o;
	logic                       page_visible_o, xfer_done_o, imm_wr_o;
	logic [3:0]                 imm_idx_o;
	logic [11:0]                echo;
	logic [32:0]                rows [6];
	int                         n_errors, checks_done, n_done;
	ortc_top dut (.*);
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) if (xfer_done_o === 1'b1) n_done++;
	always @(posedge core_clk_i) if (imm_wr_o === 1'b1) echo <= {imm_idx_o, imm_wdata_o};
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] s, input logic [3:0] i, input logic [7:0] d);
		@(negedge core_clk_i);
		cpu_req_i = '{1'b1, 1'b0, s, i, d};
		@(negedge core_clk_i);
		cpu_req_i.wr = 1'b0;
	endtask
	task automatic rd;
		@(negedge core_clk_i);
		cpu_req_i = '{1'b0, 1'b1, ortc_pkg::SEL_CONTROL, 4'h0, 8'h00};
		@(negedge core_clk_i);
		cpu_req_i.rd = 1'b0;
		@(negedge core_clk_i);
	endtask
	// Copy lands on the first rising edge after the fall
	task automatic fall;
		@(negedge core_clk_i);
		horizontal_sync_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		horizontal_sync_i = 1'b1;
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#30000;
		n_errors++;
		summarize();
	end
	initial begin
		logic [7:0] c, u, l;
		logic       vs;
		rows = '{{8'h05, 8'h10, 8'h20, 8'h05, 1'b1}, {8'h07, 8'h10, 8'h20, 8'h05, 1'b0},
			{8'h07, 8'h10, 8'h20, 8'h10, 1'b1}, {8'h07, 8'h10, 8'h20, 8'h20, 1'b1},
			{8'h07, 8'h10, 8'h20, 8'h21, 1'b0}, {8'h04, 8'h10, 8'h20, 8'h10, 1'b0}};
		ce_i = 1'b1;
		rst_n_i = 1'b0;
		horizontal_sync_i = 1'b1;
		in_display_line_i = 1'b0;
		scan_line_i = 8'h00;
		cpu_req_i = '0;
		repeat (3) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		rd();
		chk("reset ctl", 18'h0, cpu_rdata_o);
		chk("reset cfg", 18'h0, engine_cfg_o);
		foreach (rows[r]) begin
			{c, u, l, scan_line_i, vs} = rows[r];
			wr(ortc_pkg::SEL_UPPER, 4'h0, u);
			wr(ortc_pkg::SEL_LOWER, 4'h0, l);
			wr(ortc_pkg::SEL_CONTROL, 4'h0, c);
			rd();
			chk("flag", 18'h1, cpu_rdata_o[2]);
			fall();
			chk("done", 18'(r + 1), 18'(n_done));
			rd();
			chk("flag", 18'h0, cpu_rdata_o[2]);
			chk("cfg", {c[0], c[1], u, l}, engine_cfg_o);
			chk("visible", vs, page_visible_o);
		end
		in_display_line_i = 1'b1;
		wr(ortc_pkg::SEL_CONTROL, 4'h0, 8'h07);
		wr(ortc_pkg::SEL_IMMEDIATE, 4'h3, 8'h3C);
		fall();
		rd();
		chk("pending", 18'h1, cpu_rdata_o[2]);
		chk("done", 18'h6, 18'(n_done));
		in_display_line_i = 1'b0;
		fall();
		chk("done", 18'h7, 18'(n_done));
		chk("cfg", 18'h31020, engine_cfg_o);
		wr(ortc_pkg::SEL_IMMEDIATE, 4'hF, 8'hA5);
		wr(ortc_pkg::SEL_IMMEDIATE, 4'h0, 8'h5A);
		repeat (3) @(negedge core_clk_i);
		chk("imm rd", 18'h5A, imm_rdata_o);
		chk("echo", 18'h05A, echo);
		cpu_req_i.idx = 4'hF;
		repeat (3) @(negedge core_clk_i);
		chk("imm rd", 18'hA5, imm_rdata_o);
		chk("done", 18'h7, 18'(n_done));
		cpu_req_i.idx = 4'h3;
		repeat (3) @(negedge core_clk_i);
		chk("imm rd", 18'h3C, imm_rdata_o);
		// Page off before the clock enable drops
		wr(ortc_pkg::SEL_CONTROL, 4'h0, 8'h04);
		fall();
		chk("cfg", 18'h01020, engine_cfg_o);
		wr(ortc_pkg::SEL_CONTROL, 4'h0, 8'h07);
		ce_i = 1'b0;
		fall();
		ce_i = 1'b1;
		chk("frozen done", 18'h8, 18'(n_done));
		chk("frozen cfg", 18'h01020, engine_cfg_o);
		fall();
		chk("done", 18'h9, 18'(n_done));
		chk("cfg", 18'h31020, engine_cfg_o);
		// Mid-run reset drops a pending request
		wr(ortc_pkg::SEL_CONTROL, 4'h0, 8'h04);
		rst_n_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		rd();
		chk("reset ctl", 18'h0, cpu_rdata_o);
		chk("reset cfg", 18'h0, engine_cfg_o);
		chk("reset vis", 18'h0, page_visible_o);
		fall();
		chk("done", 18'h9, 18'(n_done));
		summarize();
	end
endmodule
